// File: common/rtcta_defines.svh
// offsets, field positions, reset values and counts of the trim and alarm
// block; included by the alarm and top design files, the checker and the bench.
`ifndef RTCTA_DEFINES_SVH
`define RTCTA_DEFINES_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RTCTA_ADDR_SUB_LO 16'hFF60
`define RTCTA_ADDR_SUB_HI 16'hFF61
`define RTCTA_ADDR_SEC 16'hFF62
`define RTCTA_ADDR_YEAR 16'hFF68
`define RTCTA_ADDR_TRIM 16'hFF82
`define RTCTA_ADDR_AMIN 16'hFF86
`define RTCTA_ADDR_AHOUR 16'hFF87
`define RTCTA_ADDR_AWEEK 16'hFF88

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RTCTA_TRIM_TIMING_BIT 7
`define RTCTA_TRIM_DIR_BIT 6
`define RTCTA_PM_BIT 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RTCTA_RST_TRIM 8'h00
`define RTCTA_RST_AMIN 8'h00
`define RTCTA_RST_AHOUR 8'h12
`define RTCTA_RST_AWEEK 8'h00
`define RTCTA_RST_HOUR 8'h12
`define RTCTA_RST_DAY 8'h01
`define RTCTA_RST_MONTH 8'h01

// ----------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------
`define RTCTA_SUB_TOP 16'h7FFF
`define RTCTA_BUF_ENTRIES 7

`endif

// File: common/rtcta_pkg.sv
// types shared by the trim and alarm block.
// assumes nothing beyond the defines header.
`default_nettype none

package rtcta_pkg;
	typedef logic [7:0] rtcta_bcd_t;
	typedef enum logic [0:0] {
		RTCTA_RUN = 1'b0,
		RTCTA_HOLD = 1'b1
	} rtcta_pause_e;
endpackage

`default_nettype wire

// File: core/rtcta_alarm.sv
// alarm minute, hour and weekday registers with range check and match.
// assumes the main block feeds the current time and the byte write port.
`default_nettype none
`include "rtcta_defines.svh"

module rtcta_alarm (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] minute_i,
	input wire logic [7:0] hour_i,
	input wire logic [2:0] week_i,
	input wire logic hour_system_select_i,
	input wire logic alarm_enable_i,
	output logic [7:0] alarm_minute_o,
	output logic [7:0] alarm_hour_o,
	output logic [7:0] alarm_weekday_mask_o,
	output logic alarm_hit_o
);
	rtcta_pkg::rtcta_bcd_t amin_ff;
	rtcta_pkg::rtcta_bcd_t ahour_ff;
	logic [7:0] aweek_ff;
	logic match_ff;
	logic min_ok;
	logic hour_ok;
	logic match;

	// ------------------------------------------------------------------
	// registers, any write order
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			amin_ff <= `RTCTA_RST_AMIN; // [R6]
			ahour_ff <= `RTCTA_RST_AHOUR; // [R7]
			aweek_ff <= `RTCTA_RST_AWEEK; // [R9]
		end else if (wr_i) begin
			if (addr_i == `RTCTA_ADDR_AMIN) begin
				amin_ff <= wdata_i; // [R16]
			end else if (addr_i == `RTCTA_ADDR_AHOUR) begin
				ahour_ff <= {2'b00, wdata_i[5:0]}; // [R16]
			end else if (addr_i == `RTCTA_ADDR_AWEEK) begin
				aweek_ff <= {1'b0, wdata_i[6:0]}; // [R9] [R16]
			end
		end
	end

	// ------------------------------------------------------------------
	// range check and match
	// ------------------------------------------------------------------
	always_comb begin
		min_ok = (amin_ff[7:4] <= 4'h5) && (amin_ff[3:0] <= 4'h9); // [R6]
		if (hour_system_select_i) begin
			hour_ok = (ahour_ff[3:0] <= 4'h9) && // [R7]
				((ahour_ff[7:4] <= 4'h1) || (ahour_ff <= 8'h23));
		end else begin
			// bit 5 is the pm flag: low half 01..12, pm half 21..32
			hour_ok = ((ahour_ff >= 8'h01 && ahour_ff <= 8'h12) || // [R7]
				(ahour_ff >= 8'h21 && ahour_ff <= 8'h32)) && // [R8]
				(ahour_ff[3:0] <= 4'h9);
		end
		match = alarm_enable_i && min_ok && hour_ok && // [R20]
			(minute_i == amin_ff) && (hour_i == ahour_ff) &&
			aweek_ff[week_i];
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			match_ff <= 1'b0;
		end else begin
			match_ff <= match;
		end
	end

	assign alarm_hit_o = match && !match_ff; // [R20]
	assign alarm_minute_o = amin_ff;
	assign alarm_hour_o = ahour_ff;
	assign alarm_weekday_mask_o = aweek_ff;
endmodule

`default_nettype wire

// File: core/rtcta_top.sv
// time counters with rate trim, counter pause, alarm and event flags.
// assumes an 8-bit register port on clk_sys_i and a 32.768 kHz pin clock.
`default_nettype none
`include "rtcta_defines.svh"

// Summary of operation
// R1 - eight-bit trim register adjusting the sub-count, cleared by reset
// R2 - timing bit 0 trims at seconds 00, 20, 40; bit 1 only at 00
// R3 - direction 0 adds twice (six-bit field minus one) to sub-count
// R4 - direction 1 subtracts twice (inverted field plus one)
// R5 - no trim when field bits 5 to 1 are all zero
// R6 - alarm minute is BCD 00-59, resets zero, invalid never matches
// R7 - alarm hour resets 12, range depends on hour system, invalid ignored
// R8 - in 12-hour mode alarm hour bit 5 means pm
// R9 - alarm weekday mask resets zero, bit 0 Sunday to bit 6 Saturday
// R10 - 12-hour midnight is 12 and noon 32; 24-hour uses 00 and 12
// R11 - software touches time counters only while pause is requested
// R12 - software sees pause status low before entering stop mode
// R13 - software drops the pause request within one second
// R14 - paused counters accessible in any order, any subset
// R15 - software programs alarm only while alarm is disabled
// R16 - alarm registers accept writes in any order
// R17 - periodic and alarm events share one interrupt, separate flags
// R18 - time writes go to a buffer, reach counter within two ticks
// R19 - hour system bit 0 selects 12-hour, bit 5 then is pm
// R20 - enabled alarm flags when minute, hour and weekday bit match
// R21 - trim changes only the sub-count at the chosen second boundary
module rtcta_top (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clk_32k_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic counter_pause_request_i,
	output logic counter_pause_status_o,
	input wire logic alarm_enable_i,
	input wire logic hour_system_select_i,
	input wire logic periodic_flag_clear_i,
	input wire logic alarm_flag_clear_i,
	output logic periodic_event_flag_o,
	output logic alarm_match_flag_o,
	output logic clock_interrupt_o
);
	logic [2:0] sync_ff;
	logic lvl_ff;
	logic tick;
	rtcta_pkg::rtcta_pause_e pause_ff;
	logic carry_ff;
	logic [15:0] sub_ff;
	logic [15:0] nxt_sub;
	logic [15:0] adj;
	logic [7:0] trim_ff;
	rtcta_pkg::rtcta_bcd_t buf_ff [`RTCTA_BUF_ENTRIES];
	logic [`RTCTA_BUF_ENTRIES-1:0] pend_ff;
	logic [`RTCTA_BUF_ENTRIES-1:0] load;
	rtcta_pkg::rtcta_bcd_t sec_ff;
	rtcta_pkg::rtcta_bcd_t min_ff;
	rtcta_pkg::rtcta_bcd_t hour_ff;
	rtcta_pkg::rtcta_bcd_t week_ff;
	rtcta_pkg::rtcta_bcd_t day_ff;
	rtcta_pkg::rtcta_bcd_t month_ff;
	rtcta_pkg::rtcta_bcd_t year_ff;
	logic ovf;
	logic sec_step;
	logic min_step;
	logic hour_step;
	logic day_step;
	logic year_step;
	logic trim_now;
	logic alarm_hit;
	logic periodic_flag_ff;
	logic alarm_flag_ff;
	logic irq_ff;
	logic [7:0] rdata_ff;
	logic [7:0] amin;
	logic [7:0] ahour;
	logic [7:0] aweek;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v,
		input logic [7:0] lim, input logic [7:0] lo);
		if (v == lim) begin
			bcd_inc = lo;
		end else if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = v + 8'h01;
		end
	endfunction

	function automatic logic [7:0] hour_inc(input logic [7:0] h,
		input logic sys24);
		if (sys24) begin
			hour_inc = bcd_inc(h, 8'h23, 8'h00); // [R10]
		end else if (h == 8'h12) begin
			hour_inc = 8'h01;
		end else if (h == 8'h11) begin
			hour_inc = 8'h32; // [R10] [R19]
		end else if (h == 8'h32) begin
			hour_inc = 8'h21;
		end else begin
			hour_inc = bcd_inc(h, 8'h31, 8'h12); // [R10]
		end
	endfunction

	// ------------------------------------------------------------------
	// 32.768 kHz pin: three stages, edge once stages two and three agree
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sync_ff <= 3'h0;
			lvl_ff <= 1'b0;
		end else begin
			sync_ff <= {sync_ff[1:0], clk_32k_i};
			if (sync_ff[1] == sync_ff[2]) begin
				lvl_ff <= sync_ff[2];
			end
		end
	end

	assign tick = (sync_ff[1] == sync_ff[2]) && sync_ff[2] && !lvl_ff;

	// ------------------------------------------------------------------
	// pause handshake; sub-count keeps running, one second is carried
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pause_ff <= rtcta_pkg::RTCTA_RUN;
		end else if (tick) begin
			case (pause_ff)
				rtcta_pkg::RTCTA_RUN: begin
					if (counter_pause_request_i) begin
						pause_ff <= rtcta_pkg::RTCTA_HOLD; // [R14]
					end
				end
				rtcta_pkg::RTCTA_HOLD: begin
					if (!counter_pause_request_i) begin
						pause_ff <= rtcta_pkg::RTCTA_RUN; // [R13]
					end
				end
				default: pause_ff <= rtcta_pkg::RTCTA_RUN;
			endcase
		end
	end

	assign counter_pause_status_o = (pause_ff == rtcta_pkg::RTCTA_HOLD);
	assign ovf = tick && (sub_ff == `RTCTA_SUB_TOP);
	assign sec_step = tick && (pause_ff == rtcta_pkg::RTCTA_RUN) &&
		(ovf || carry_ff);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			carry_ff <= 1'b0;
		end else if (ovf && !sec_step) begin
			carry_ff <= 1'b1; // [R13]
		end else if (sec_step) begin
			carry_ff <= ovf && carry_ff;
		end
	end

	// ------------------------------------------------------------------
	// rate trim of the sub-count
	// ------------------------------------------------------------------
	always_comb begin
		trim_now = (trim_ff[5:1] != 5'h00) && // [R5]
			((bcd_inc(sec_ff, 8'h59, 8'h00) == 8'h00) || // [R2]
			(!trim_ff[`RTCTA_TRIM_TIMING_BIT] &&
			((bcd_inc(sec_ff, 8'h59, 8'h00) == 8'h20) ||
			(bcd_inc(sec_ff, 8'h59, 8'h00) == 8'h40))));
		if (trim_ff[`RTCTA_TRIM_DIR_BIT]) begin
			adj = {9'h000, ~trim_ff[5:0] + 6'h01, 1'b0}; // [R4]
		end else begin
			adj = {9'h000, trim_ff[5:0] - 6'h01, 1'b0}; // [R3]
		end
		nxt_sub = sub_ff + 16'h0001;
		if (ovf) begin
			if (!trim_now) begin
				nxt_sub = 16'h0000;
			end else if (trim_ff[`RTCTA_TRIM_DIR_BIT]) begin
				nxt_sub = (16'h0000 - adj) & `RTCTA_SUB_TOP; // [R4] [R21]
			end else begin
				nxt_sub = adj; // [R3] [R21]
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sub_ff <= 16'h0000;
		end else if (tick) begin
			sub_ff <= nxt_sub;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			trim_ff <= `RTCTA_RST_TRIM; // [R1]
		end else if (wr_i && addr_i == `RTCTA_ADDR_TRIM) begin
			trim_ff <= wdata_i; // [R1]
		end
	end

	// ------------------------------------------------------------------
	// write buffer per time register, moved on the next tick
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `RTCTA_BUF_ENTRIES; gi++) begin : g_buf
			logic hit;
			assign hit = wr_i && (addr_i == `RTCTA_ADDR_SEC + 16'(gi));
			assign load[gi] = tick && pend_ff[gi] && !hit; // [R18]
			always_ff @(posedge clk_sys_i) begin
				if (!rst_n_i) begin
					buf_ff[gi] <= 8'h00;
					pend_ff[gi] <= 1'b0;
				end else if (hit) begin
					buf_ff[gi] <= wdata_i; // [R14] [R18]
					pend_ff[gi] <= 1'b1;
				end else if (load[gi]) begin
					pend_ff[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// time counters, index order sec, min, hour, week, day, month, year
	// ------------------------------------------------------------------
	assign min_step = sec_step && (sec_ff == 8'h59);
	assign hour_step = min_step && (min_ff == 8'h59);
	assign day_step = hour_step &&
		(hour_ff == (hour_system_select_i ? 8'h23 : 8'h31)); // [R10]
	assign year_step = day_step && (day_ff == 8'h31) && (month_ff == 8'h12);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sec_ff <= 8'h00;
			min_ff <= 8'h00;
			hour_ff <= `RTCTA_RST_HOUR;
			week_ff <= 8'h00;
		end else begin
			if (load[0]) begin
				sec_ff <= buf_ff[0]; // [R18]
			end else if (sec_step) begin
				sec_ff <= bcd_inc(sec_ff, 8'h59, 8'h00);
			end
			if (load[1]) begin
				min_ff <= buf_ff[1];
			end else if (min_step) begin
				min_ff <= bcd_inc(min_ff, 8'h59, 8'h00);
			end
			if (load[2]) begin
				hour_ff <= buf_ff[2];
			end else if (hour_step) begin
				hour_ff <= hour_inc(hour_ff, hour_system_select_i); // [R10]
			end
			if (load[3]) begin
				week_ff <= buf_ff[3];
			end else if (day_step) begin
				week_ff <= bcd_inc(week_ff, 8'h06, 8'h00);
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			day_ff <= `RTCTA_RST_DAY;
			month_ff <= `RTCTA_RST_MONTH;
			year_ff <= 8'h00;
		end else begin
			if (load[4]) begin
				day_ff <= buf_ff[4];
			end else if (day_step) begin
				day_ff <= bcd_inc(day_ff, 8'h31, 8'h01);
			end
			if (load[5]) begin
				month_ff <= buf_ff[5];
			end else if (day_step && day_ff == 8'h31) begin
				month_ff <= bcd_inc(month_ff, 8'h12, 8'h01);
			end
			if (load[6]) begin
				year_ff <= buf_ff[6];
			end else if (year_step) begin
				year_ff <= bcd_inc(year_ff, 8'h99, 8'h00);
			end
		end
	end

	// ------------------------------------------------------------------
	// alarm and shared event flags
	// ------------------------------------------------------------------
	rtcta_alarm i_rtcta_alarm (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_i(wr_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.minute_i(min_ff),
		.hour_i(hour_ff),
		.week_i(week_ff[2:0]),
		.hour_system_select_i(hour_system_select_i),
		.alarm_enable_i(alarm_enable_i),
		.alarm_minute_o(amin),
		.alarm_hour_o(ahour),
		.alarm_weekday_mask_o(aweek),
		.alarm_hit_o(alarm_hit)
	);

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			periodic_flag_ff <= 1'b0;
			alarm_flag_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			// set wins over a clear in the same cycle
			if (sec_step) begin
				periodic_flag_ff <= 1'b1; // [R17]
			end else if (periodic_flag_clear_i) begin
				periodic_flag_ff <= 1'b0;
			end
			if (alarm_hit) begin
				alarm_flag_ff <= 1'b1; // [R17] [R20]
			end else if (alarm_flag_clear_i) begin
				alarm_flag_ff <= 1'b0;
			end
			irq_ff <= sec_step || alarm_hit; // [R17]
		end
	end

	assign periodic_event_flag_o = periodic_flag_ff;
	assign alarm_match_flag_o = alarm_flag_ff;
	assign clock_interrupt_o = irq_ff;

	// ------------------------------------------------------------------
	// register read
	// ------------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == `RTCTA_ADDR_SUB_LO) begin
				rdata_ff <= sub_ff[7:0];
			end else if (addr_i == `RTCTA_ADDR_SUB_HI) begin
				rdata_ff <= sub_ff[15:8];
			end else if (addr_i == `RTCTA_ADDR_SEC) begin
				rdata_ff <= sec_ff; // [R14]
			end else if (addr_i == `RTCTA_ADDR_SEC + 16'h0001) begin
				rdata_ff <= min_ff;
			end else if (addr_i == `RTCTA_ADDR_SEC + 16'h0002) begin
				rdata_ff <= hour_ff;
			end else if (addr_i == `RTCTA_ADDR_SEC + 16'h0003) begin
				rdata_ff <= week_ff;
			end else if (addr_i == `RTCTA_ADDR_SEC + 16'h0004) begin
				rdata_ff <= day_ff;
			end else if (addr_i == `RTCTA_ADDR_SEC + 16'h0005) begin
				rdata_ff <= month_ff;
			end else if (addr_i == `RTCTA_ADDR_YEAR) begin
				rdata_ff <= year_ff;
			end else if (addr_i == `RTCTA_ADDR_TRIM) begin
				rdata_ff <= trim_ff;
			end else if (addr_i == `RTCTA_ADDR_AMIN) begin
				rdata_ff <= amin;
			end else if (addr_i == `RTCTA_ADDR_AHOUR) begin
				rdata_ff <= ahour;
			end else if (addr_i == `RTCTA_ADDR_AWEEK) begin
				rdata_ff <= aweek;
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end

	assign rdata_o = rdata_ff;
endmodule

`default_nettype wire

// File: sim/rtcta_props.sv
// assertions on the port behaviour of the trim and alarm block.
// assumes a bind to rtcta_top from the bench top file.
`default_nettype none
`include "rtcta_defines.svh"

module rtcta_props (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic clk_32k_i,
	input wire logic [15:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] rdata_o,
	input wire logic counter_pause_request_i,
	input wire logic counter_pause_status_o,
	input wire logic alarm_enable_i,
	input wire logic hour_system_select_i,
	input wire logic periodic_flag_clear_i,
	input wire logic alarm_flag_clear_i,
	input wire logic periodic_event_flag_o,
	input wire logic alarm_match_flag_o,
	input wire logic clock_interrupt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	trim_readback_a: assert property (
		rd_i && addr_i == `RTCTA_ADDR_TRIM && $past(wr_i, 2) && !$past(wr_i)
		&& $past(addr_i, 2) == `RTCTA_ADDR_TRIM
		|=> rdata_o == $past(wdata_i, 3))
		else $error("trim readback differs from written value");
	hour_top_bits_a: assert property (
		rd_i && addr_i == `RTCTA_ADDR_AHOUR |=> rdata_o[7:6] == 2'b00)
		else $error("alarm hour top bits not zero");
	week_top_bit_a: assert property (
		rd_i && addr_i == `RTCTA_ADDR_AWEEK |=> !rdata_o[7])
		else $error("alarm weekday bit 7 not zero");
	rdata_hold_a: assert property (!rd_i |=> $stable(rdata_o))
		else $error("read data changed without a read");
	irq_pulse_a: assert property (
		clock_interrupt_o |=> !clock_interrupt_o)
		else $error("interrupt longer than one cycle");
	periodic_irq_a: assert property (
		$rose(periodic_event_flag_o) |-> clock_interrupt_o)
		else $error("periodic flag set without interrupt");
	alarm_irq_a: assert property (
		$rose(alarm_match_flag_o) |-> clock_interrupt_o)
		else $error("alarm flag set without interrupt");
	periodic_hold_a: assert property (
		periodic_event_flag_o && !periodic_flag_clear_i
		|=> periodic_event_flag_o)
		else $error("periodic flag dropped without clear");
	alarm_hold_a: assert property (
		alarm_match_flag_o && !alarm_flag_clear_i |=> alarm_match_flag_o)
		else $error("alarm flag dropped without clear");
	alarm_off_a: assert property (
		!alarm_enable_i && !$past(alarm_enable_i)
		&& !$past(alarm_enable_i, 2) |-> !$rose(alarm_match_flag_o))
		else $error("alarm flag set while disabled");
	pause_follow_a: assert property (
		$changed(counter_pause_status_o)
		|-> counter_pause_status_o == $past(counter_pause_request_i))
		else $error("pause status moved against request");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	alarm_seen_c: cover property ($rose(alarm_match_flag_o));
	second_seen_c: cover property ($rose(periodic_event_flag_o));
	pause_seen_c: cover property ($rose(counter_pause_status_o));
endmodule

`default_nettype wire

// File: sim/rtcta_top_tb.sv
// self-checking bench for the trim and alarm block.
// assumes rtcta_top and rtcta_props; count clock runs fast.
`default_nettype none
`include "rtcta_defines.svh"

`define CHK(nm, exp, got) begin \
	checks_done++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("BAD %s exp %h got %h", nm, exp, got); \
	end \
end

module rtcta_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic clk_32k_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic counter_pause_request_i = 1'b0;
	logic alarm_enable_i = 1'b0;
	logic hour_system_select_i = 1'b1;
	logic periodic_flag_clear_i = 1'b0;
	logic alarm_flag_clear_i = 1'b0;
	logic [7:0] rdata_o;
	logic counter_pause_status_o;
	logic periodic_event_flag_o;
	logic alarm_match_flag_o;
	logic clock_interrupt_o;
	int err_total = 0;
	int checks_done = 0;
	int cycles = 0;
	int ticks = 0;
	int last_tick = 0;
	int dt;
	logic [7:0] rd_v;
	logic [15:0] ra [8] = '{16'hFF82, 16'hFF86, 16'hFF87, 16'hFF88,
		16'hFF62, 16'hFF64, 16'hFF66, 16'hFF90};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h12, 8'h00,
		8'h00, 8'h12, 8'h01, 8'h00};

	rtcta_top i_rtcta_top (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.clk_32k_i(clk_32k_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
		.wdata_i(wdata_i), .rdata_o(rdata_o),
		.counter_pause_request_i(counter_pause_request_i),
		.counter_pause_status_o(counter_pause_status_o),
		.alarm_enable_i(alarm_enable_i),
		.hour_system_select_i(hour_system_select_i),
		.periodic_flag_clear_i(periodic_flag_clear_i),
		.alarm_flag_clear_i(alarm_flag_clear_i),
		.periodic_event_flag_o(periodic_event_flag_o),
		.alarm_match_flag_o(alarm_match_flag_o),
		.clock_interrupt_o(clock_interrupt_o));

	// ----------------------------------------------------------------
	// clocks and watchdog
	// ----------------------------------------------------------------
	always #12.5 clk_sys_i = ~clk_sys_i;
	// count clock shortened to four system cycles a tick
	always #50 clk_32k_i = ~clk_32k_i;
	always @(posedge clk_32k_i) ticks++;
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 160000) begin
			err_total++;
			report_and_stop();
		end
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		@(negedge clk_sys_i);
		d = rdata_o;
		@(posedge clk_sys_i);
	endtask

	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		rd(a, rd_v);
		`CHK($sformatf("reg %h", a), e, rd_v)
	endtask

	task automatic pause(input logic on);
		int n;
		n = 0;
		counter_pause_request_i <= on;
		while (counter_pause_status_o !== on && n < 40) begin
			@(posedge clk_sys_i);
			n++;
		end
		`CHK("pause status", on, counter_pause_status_o)
	endtask

	task automatic sec_tick(output int d);
		while (periodic_event_flag_o !== 1'b1) @(posedge clk_sys_i);
		d = ticks - last_tick;
		last_tick = ticks;
		periodic_flag_clear_i <= 1'b1;
		@(posedge clk_sys_i);
		periodic_flag_clear_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	task automatic alarm_case(input logic s24, input logic [7:0] th,
		input logic [7:0] ah, input logic [2:0] wk, input logic [7:0] wm,
		input logic e);
		hour_system_select_i <= s24;
		pause(1'b1);
		wr(16'hFF63, 8'h45);
		wr(16'hFF64, th);
		wr(16'hFF65, {5'h00, wk});
		repeat (12) @(posedge clk_sys_i);
		pause(1'b0);
		wr(`RTCTA_ADDR_AWEEK, wm);
		wr(`RTCTA_ADDR_AHOUR, ah);
		wr(`RTCTA_ADDR_AMIN, 8'h45);
		alarm_enable_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		`CHK("alarm flag", e, alarm_match_flag_o)
		alarm_enable_i <= 1'b0;
		alarm_flag_clear_i <= 1'b1;
		@(posedge clk_sys_i);
		alarm_flag_clear_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		pause(1'b1);
		foreach (ra[i])
			rchk(ra[i], rv[i]);
		pause(1'b0);
		wr(`RTCTA_ADDR_AWEEK, 8'hFF);
		wr(`RTCTA_ADDR_AHOUR, 8'hFF);
		wr(`RTCTA_ADDR_AMIN, 8'h59);
		wr(`RTCTA_ADDR_TRIM, 8'hA5);
		rchk(`RTCTA_ADDR_TRIM, 8'hA5);
		rchk(`RTCTA_ADDR_AMIN, 8'h59);
		rchk(`RTCTA_ADDR_AHOUR, 8'h3F);
		rchk(`RTCTA_ADDR_AWEEK, 8'h7F);
		alarm_case(1'b1, 8'h13, 8'h13, 3'd3, 8'h08, 1'b1);
		alarm_case(1'b1, 8'h13, 8'h13, 3'd3, 8'h77, 1'b0);
		alarm_case(1'b1, 8'h25, 8'h25, 3'd3, 8'h08, 1'b0);
		alarm_case(1'b0, 8'h00, 8'h00, 3'd3, 8'h08, 1'b0);
		alarm_case(1'b0, 8'h32, 8'h32, 3'd6, 8'h40, 1'b1);
		alarm_case(1'b0, 8'h32, 8'h12, 3'd6, 8'h40, 1'b0);
		alarm_case(1'b0, 8'h12, 8'h12, 3'd0, 8'h01, 1'b1);
		wr(`RTCTA_ADDR_TRIM, 8'hC2);
		pause(1'b1);
		wr(`RTCTA_ADDR_SEC, 8'h59);
		repeat (12) @(posedge clk_sys_i);
		rchk(`RTCTA_ADDR_SEC, 8'h59);
		pause(1'b0);
		sec_tick(dt);
		`CHK("alarm flag", 1'b0, alarm_match_flag_o)
		pause(1'b1);
		rchk(`RTCTA_ADDR_SEC, 8'h00);
		wr(`RTCTA_ADDR_TRIM, 8'h42);
		wr(`RTCTA_ADDR_SEC, 8'h19);
		pause(1'b0);
		sec_tick(dt);
		`CHK("ticks after 00", 124, dt)
		pause(1'b1);
		rchk(`RTCTA_ADDR_SEC, 8'h20);
		wr(`RTCTA_ADDR_TRIM, 8'h3F);
		wr(`RTCTA_ADDR_SEC, 8'h39);
		pause(1'b0);
		sec_tick(dt);
		`CHK("ticks after 20", 124, dt)
		rd(`RTCTA_ADDR_SUB_LO, rd_v);
		`CHK("sub low", 6'h1F, rd_v[7:2])
		rchk(`RTCTA_ADDR_SUB_HI, 8'h00);
		report_and_stop();
	end
endmodule

bind rtcta_top rtcta_props i_rtcta_props (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .clk_32k_i(clk_32k_i), .addr_i(addr_i),
	.wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
	.counter_pause_request_i(counter_pause_request_i),
	.counter_pause_status_o(counter_pause_status_o),
	.alarm_enable_i(alarm_enable_i),
	.hour_system_select_i(hour_system_select_i),
	.periodic_flag_clear_i(periodic_flag_clear_i),
	.alarm_flag_clear_i(alarm_flag_clear_i),
	.periodic_event_flag_o(periodic_event_flag_o),
	.alarm_match_flag_o(alarm_match_flag_o),
	.clock_interrupt_o(clock_interrupt_o));

`default_nettype wire
